/* File: design/adss_defs.vh */
// register map, field positions, reset values and timing counts
`ifndef ADSS_DEFS_VH
`define ADSS_DEFS_VH
`define ADSS_OFS_CTRL 3'h0
`define ADSS_OFS_CLK 3'h1
`define ADSS_OFS_STAT 3'h2
`define ADSS_OFS_TRIG 3'h3
`define ADSS_OFS_GACT 3'h4
`define ADSS_OFS_RESULT 3'h5
`define ADSS_OFS_FIFO 3'h6
`define ADSS_CTRL_MSTOP 0
`define ADSS_CTRL_SYNC0 1
`define ADSS_CTRL_SYNC1 2
`define ADSS_CTRL_CAL 3
`define ADSS_CTRL_MODE_LO 4
`define ADSS_CTRL_MODE_HI 6
`define ADSS_CTRL_IRQEN 7
`define ADSS_CTRL_DUMMY 8
`define ADSS_CTRL_FIFOEN 9
`define ADSS_CTRL_DIAG 10
`define ADSS_CTRL_RST 11'h001
`define ADSS_CLK_EN 0
`define ADSS_CLK_SRC_LO 1
`define ADSS_CLK_SRC_HI 2
`define ADSS_CLK_DIV_LO 4
`define ADSS_CLK_DIV_HI 7
`define ADSS_CLK_RST 8'h00
`define ADSS_SRC_TIMER 2'h2
`define ADSS_MODE_SAR_SINGLE 3'h0
`define ADSS_MODE_SAR_CONT 3'h1
`define ADSS_MODE_OS_SINGLE 3'h2
`define ADSS_MODE_OS_CONT 3'h3
`define ADSS_MODE_HY_SINGLE 3'h4
`define ADSS_MODE_HY_CONT 3'h5
`define ADSS_MODE_HY_BG 3'h6
`define ADSS_NGRP 9
`define ADSS_SUPPLY_LAT 4'h4
`define ADSS_CAL_TICKS 8'h20
`define ADSS_SCAN_TICKS 8'h10
`endif

/* File: design/adss_clk_gate.v */
// converter clock gate with supply status handshake and divider
`timescale 1ns/1ps
module adss_clk_gate (
  input wire clk_in,
  input wire rst_n_in,
  input wire enable_in,
  input wire [3:0] div_in,
  output wire supply_status_out,
  output wire tick_out
);
`include "adss_defs.vh"
  reg [3:0] lat_r;
  reg status_r;
  reg [3:0] div_cnt_r;
  reg tick_r;
  // status follows the enable only after the gate has really switched
  always @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      lat_r <= 4'h0;
      status_r <= 1'b0;
    end else if (enable_in == status_r) begin
      lat_r <= 4'h0;
    end else if (lat_r == `ADSS_SUPPLY_LAT - 4'h1) begin
      lat_r <= 4'h0;
      status_r <= enable_in;
    end else begin
      lat_r <= lat_r + 4'h1;
    end
  end
  always @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      div_cnt_r <= 4'h0;
      tick_r <= 1'b0;
    end else if (!status_r) begin
      div_cnt_r <= 4'h0;
      tick_r <= 1'b0;
    end else if (div_cnt_r >= div_in) begin
      div_cnt_r <= 4'h0;
      tick_r <= 1'b1;
    end else begin
      div_cnt_r <= div_cnt_r + 4'h1;
      tick_r <= 1'b0;
    end
  end
  assign supply_status_out = status_r;
  assign tick_out = tick_r;
endmodule // adss_clk_gate

/* File: design/adss_top.v */
// converter setup, clock handshake, calibration and scan sequencing
//
// Decided for this implementation: the placing of the registers and register access over Avalon-MM.
`timescale 1ns/1ps
module adss_top (
  input wire clk_sys_in,
  input wire arst_n_in,
  input wire [2:0] avs_address,
  input wire avs_read,
  input wire avs_write,
  input wire [31:0] avs_writedata,
  output reg [31:0] avs_readdata,
  output wire avs_waitrequest,
  input wire [8:0] periph_trig_in,
  input wire [15:0] conv_data_in,
  input wire conv_ready_in,
  output wire converter_clock_tick_out,
  output wire [1:0] clk_source_out,
  output wire [1:0] sync_enable_out,
  output wire [1:0] converter_active_flag_out,
  output wire [8:0] group_active_flag_out,
  output wire conv_start_out,
  output wire diag_enable_out,
  output wire timer_source_sel_out,
  output wire scan_end_interrupt_out
);
`include "adss_defs.vh"
  localparam ST_IDLE = 2'h0;
  localparam ST_CAL = 2'h1;
  localparam ST_SCAN = 2'h2;
  localparam ST_BG = 2'h3;
  reg rst_meta_r;
  reg rst_n_r;
  reg ack_r;
  reg [10:0] ctrl_r;
  reg [7:0] clk_r;
  reg [8:0] trig_en_r;
  reg [8:0] pend_r;
  reg [8:0] gact_r;
  reg [3:0] grp_r;
  reg [1:0] state_r;
  reg [7:0] tick_cnt_r;
  reg cal_done_r;
  reg [15:0] latest_r;
  reg [15:0] result_r;
  reg [15:0] fifo_r;
  reg fifo_valid_r;
  reg irq_r;
  reg start_r;
  wire supply_st;
  wire tick;
  wire wr_go;
  wire rd_go;
  wire [2:0] mode;
  wire diag_ok;
  wire [8:0] sw_trig;
  wire [8:0] new_trig;
  wire can_scan;
  function [3:0] first_set;
    input [8:0] vec;
    integer i;
    begin
      first_set = 4'h0;
      for (i = `ADSS_NGRP - 1; i >= 0; i = i - 1) begin
        if (vec[i]) begin
          first_set = i[3:0];
        end
      end
    end
  endfunction
  always @(posedge clk_sys_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      rst_meta_r <= 1'b0;
      rst_n_r <= 1'b0;
    end else begin
      rst_meta_r <= 1'b1;
      rst_n_r <= rst_meta_r;
    end
  end
  // one wait cycle on every access, answer on the second
  assign avs_waitrequest = (avs_read | avs_write) & ~ack_r;
  assign wr_go = avs_write & ack_r;
  assign rd_go = avs_read & ~ack_r;
  always @(posedge clk_sys_in or negedge rst_n_r) begin
    if (!rst_n_r) begin
      ack_r <= 1'b0;
    end else begin
      ack_r <= (avs_read | avs_write) & ~ack_r;
    end
  end
  assign mode = ctrl_r[`ADSS_CTRL_MODE_HI:`ADSS_CTRL_MODE_LO];
  assign diag_ok = (mode == `ADSS_MODE_SAR_SINGLE) | (mode == `ADSS_MODE_SAR_CONT)
    | (mode == `ADSS_MODE_OS_SINGLE) | (mode == `ADSS_MODE_HY_SINGLE)
    | (((mode == `ADSS_MODE_HY_CONT) | (mode == `ADSS_MODE_HY_BG))
       & ctrl_r[`ADSS_CTRL_DUMMY]);
  assign sw_trig = (wr_go && avs_address == `ADSS_OFS_TRIG) ? avs_writedata[24:16] : 9'h000;
  assign new_trig = sw_trig | (periph_trig_in & trig_en_r);
  assign can_scan = ~ctrl_r[`ADSS_CTRL_MSTOP] & supply_st & cal_done_r;
  always @(posedge clk_sys_in or negedge rst_n_r) begin
    if (!rst_n_r) begin
      ctrl_r <= `ADSS_CTRL_RST;
      clk_r <= `ADSS_CLK_RST;
      trig_en_r <= 9'h000;
    end else if (wr_go) begin
      if (avs_address == `ADSS_OFS_CTRL) begin
        ctrl_r <= avs_writedata[10:0] & 11'h7F7;
      end
      if (avs_address == `ADSS_OFS_CLK) begin
        clk_r <= avs_writedata[7:0] & 8'hF7;
      end
      if (avs_address == `ADSS_OFS_TRIG) begin
        trig_en_r <= avs_writedata[8:0];
      end
    end
  end
  adss_clk_gate u_gate (
    .clk_in(clk_sys_in),
    .rst_n_in(rst_n_r),
    .enable_in(clk_r[`ADSS_CLK_EN]),
    .div_in(clk_r[`ADSS_CLK_DIV_HI:`ADSS_CLK_DIV_LO]),
    .supply_status_out(supply_st),
    .tick_out(tick)
  );
  always @(posedge clk_sys_in or negedge rst_n_r) begin
    if (!rst_n_r) begin
      latest_r <= 16'h0000;
    end else if (conv_ready_in) begin
      latest_r <= conv_data_in;
    end
  end
  // sequencer: calibration, scans and background output
  always @(posedge clk_sys_in or negedge rst_n_r) begin
    if (!rst_n_r) begin
      state_r <= ST_IDLE;
      pend_r <= 9'h000;
      gact_r <= 9'h000;
      grp_r <= 4'h0;
      tick_cnt_r <= 8'h00;
      cal_done_r <= 1'b0;
      result_r <= 16'h0000;
      fifo_r <= 16'h0000;
      fifo_valid_r <= 1'b0;
      irq_r <= 1'b0;
      start_r <= 1'b0;
    end else begin
      irq_r <= 1'b0;
      start_r <= 1'b0;
      if (rd_go && avs_address == `ADSS_OFS_FIFO) begin
        fifo_valid_r <= 1'b0;
      end
      if (ctrl_r[`ADSS_CTRL_MSTOP] || !supply_st) begin
        state_r <= ST_IDLE;
        pend_r <= 9'h000;
        gact_r <= 9'h000;
        cal_done_r <= 1'b0;
      end else begin
        if (can_scan) begin
          pend_r <= pend_r | new_trig;
        end
        case (state_r)
          ST_IDLE: begin
            if (wr_go && avs_address == `ADSS_OFS_CTRL && avs_writedata[`ADSS_CTRL_CAL]) begin
              state_r <= ST_CAL;
              cal_done_r <= 1'b0;
              tick_cnt_r <= 8'h00;
            end else if (can_scan && (pend_r != 9'h000)) begin
              grp_r <= first_set(pend_r);
              gact_r[first_set(pend_r)] <= 1'b1;
              pend_r[first_set(pend_r)] <= 1'b0;
              tick_cnt_r <= 8'h00;
              start_r <= 1'b1;
              state_r <= ST_SCAN;
            end
          end
          ST_CAL: begin
            if (tick) begin
              tick_cnt_r <= tick_cnt_r + 8'h01;
              if (tick_cnt_r == `ADSS_CAL_TICKS - 8'h01) begin
                cal_done_r <= 1'b1;
                state_r <= ST_IDLE;
              end
            end
          end
          ST_SCAN: begin
            if (tick) begin
              tick_cnt_r <= tick_cnt_r + 8'h01;
              if (tick_cnt_r == `ADSS_SCAN_TICKS - 8'h01) begin
                tick_cnt_r <= 8'h00;
                if (mode == `ADSS_MODE_HY_BG) begin
                  state_r <= ST_BG;
                end else begin
                  result_r <= latest_r;
                  if (ctrl_r[`ADSS_CTRL_FIFOEN]) begin
                    fifo_r <= latest_r;
                    fifo_valid_r <= 1'b1;
                  end
                  irq_r <= ctrl_r[`ADSS_CTRL_IRQEN];
                  if (mode == `ADSS_MODE_SAR_CONT || mode == `ADSS_MODE_OS_CONT ||
                      mode == `ADSS_MODE_HY_CONT) begin
                    start_r <= 1'b1;
                  end else begin
                    gact_r[grp_r] <= 1'b0;
                    state_r <= ST_IDLE;
                  end
                end
              end
            end
          end
          ST_BG: begin
            // group keeps converting; each of its triggers outputs latest data
            if (can_scan && new_trig[grp_r]) begin
              result_r <= latest_r;
              if (ctrl_r[`ADSS_CTRL_FIFOEN]) begin
                fifo_r <= latest_r;
                fifo_valid_r <= 1'b1;
              end
              irq_r <= ctrl_r[`ADSS_CTRL_IRQEN];
              pend_r[grp_r] <= 1'b0;
            end
            if (mode != `ADSS_MODE_HY_BG) begin
              gact_r[grp_r] <= 1'b0;
              state_r <= ST_IDLE;
            end
          end
          default: begin
            state_r <= ST_IDLE;
          end
        endcase
      end
    end
  end
  always @(posedge clk_sys_in or negedge rst_n_r) begin
    if (!rst_n_r) begin
      avs_readdata <= 32'h00000000;
    end else if (rd_go) begin
      case (avs_address)
        `ADSS_OFS_CTRL: avs_readdata <= {21'h0, ctrl_r & 11'h7F7};
        `ADSS_OFS_CLK: avs_readdata <= {24'h000000, clk_r};
        `ADSS_OFS_STAT: avs_readdata <= {26'h0, diag_ok, fifo_valid_r,
          converter_active_flag_out, cal_done_r, supply_st};
        `ADSS_OFS_TRIG: avs_readdata <= {23'h0, trig_en_r};
        `ADSS_OFS_GACT: avs_readdata <= {23'h0, gact_r};
        `ADSS_OFS_RESULT: avs_readdata <= {16'h0000, result_r};
        `ADSS_OFS_FIFO: avs_readdata <= {16'h0000, fifo_r};
        default: avs_readdata <= 32'h00000000;
      endcase
    end
  end
  assign converter_clock_tick_out = tick;
  assign clk_source_out = clk_r[`ADSS_CLK_SRC_HI:`ADSS_CLK_SRC_LO];
  assign timer_source_sel_out = (clk_source_out == `ADSS_SRC_TIMER);
  assign sync_enable_out = ~ctrl_r[`ADSS_CTRL_SYNC1:`ADSS_CTRL_SYNC0];
  assign converter_active_flag_out = {(state_r == ST_SCAN || state_r == ST_BG)
    & ~ctrl_r[`ADSS_CTRL_SYNC1], (state_r == ST_SCAN || state_r == ST_BG)};
  assign group_active_flag_out = gact_r;
  assign conv_start_out = start_r;
  assign diag_enable_out = ctrl_r[`ADSS_CTRL_DIAG] & diag_ok;
  assign scan_end_interrupt_out = irq_r;
endmodule // adss_top

/* File: tb/adss_checker.sv */
// port-level properties of the converter sequencer
`timescale 1ns/1ps
module adss_checker (
  input wire clk_sys_in,
  input wire arst_n_in,
  input wire [2:0] avs_address,
  input wire avs_write,
  input wire [31:0] avs_writedata,
  input wire avs_waitrequest,
  input wire converter_clock_tick_out,
  input wire [1:0] sync_enable_out,
  input wire [1:0] converter_active_flag_out,
  input wire conv_start_out,
  input wire diag_enable_out,
  input wire scan_end_interrupt_out
);
  default clocking @(posedge clk_sys_in); endclocking
  default disable iff (!arst_n_in);
  wire wr_ok = avs_write && !avs_waitrequest;
  reg [10:0] ctrl_r;
  wire [2:0] md = ctrl_r[6:4];
  // shadow of the control word as written
  always @(posedge clk_sys_in or negedge arst_n_in) begin
    if (!arst_n_in) ctrl_r <= 11'h001;
    else if (wr_ok && avs_address == 3'h0) ctrl_r <= avs_writedata[10:0];
  end
  sequence clk_wr_s(bit en);
    wr_ok && avs_address == 3'h1 && avs_writedata[0] == en && avs_writedata[7:4] == 4'h0;
  endsequence
  diag_hybrid_a: assert property (md > 3'h4 && md < 3'h7 |-> diag_enable_out == (ctrl_r[10] && ctrl_r[8]))
    else $error("diagnosis enable wrong in hybrid continuous");
  diag_mode_a: assert property (md < 3'h5 |-> diag_enable_out == (ctrl_r[10] && md != 3'h3))
    else $error("diagnosis enable wrong for scan mode");
  sync_reset_a: assert property ($rose(arst_n_in) |-> sync_enable_out == 2'h3)
    else $error("sync not enabled after reset");
  sync_bits_a: assert property (sync_enable_out == ~ctrl_r[2:1])
    else $error("sync enable does not follow disable bits");
  tick_stop_a: assert property (clk_wr_s(1'b0) |=> ##5 !converter_clock_tick_out [*4])
    else $error("converter clock still running after disable");
  tick_start_a: assert property (clk_wr_s(1'b1) |-> ##[1:8] converter_clock_tick_out)
    else $error("converter clock not supplied after enable");
  start_busy_a: assert property (conv_start_out |-> ##[0:2] converter_active_flag_out[0])
    else $error("scan start without active converter");
  irq_pulse_a: assert property (scan_end_interrupt_out |-> ctrl_r[7] ##1 !scan_end_interrupt_out)
    else $error("scan end pulse wrong");
endmodule // adss_checker
bind adss_top adss_checker u_chk (.clk_sys_in(clk_sys_in), .arst_n_in(arst_n_in),
  .avs_address(avs_address), .avs_write(avs_write), .avs_writedata(avs_writedata),
  .avs_waitrequest(avs_waitrequest), .converter_clock_tick_out(converter_clock_tick_out),
  .sync_enable_out(sync_enable_out), .converter_active_flag_out(converter_active_flag_out),
  .conv_start_out(conv_start_out), .diag_enable_out(diag_enable_out),
  .scan_end_interrupt_out(scan_end_interrupt_out));

/* File: tb/adss_top_test.sv */
// self-checking bench for the converter sequencer
`timescale 1ns/1ps
`define CHK(g, e) begin compares = compares + 1; if ((g) !== (e)) begin \
  n_errors = n_errors + 1; $display("[FAIL] %0t got %h exp %h", $time, g, e); end end
module adss_top_test;
  reg clk_sys_in = 1'b0;
  reg arst_n_in = 1'b0;
  reg [2:0] avs_address = 3'h0;
  reg avs_read = 1'b0;
  reg avs_write = 1'b0;
  reg [31:0] avs_writedata = 32'h0;
  reg [8:0] periph_trig_in = 9'h0;
  reg [15:0] conv_data_in = 16'h0;
  reg conv_ready_in = 1'b0;
  wire [31:0] avs_readdata;
  wire avs_waitrequest, tick, tsel, diag, irq, cstart;
  wire [1:0] src, sync_en, act;
  wire [8:0] gact;
  integer n_errors = 0;
  integer compares = 0;
  integer m, d;
  reg [31:0] q;
  always #5 clk_sys_in = ~clk_sys_in;
  adss_top dut (.clk_sys_in(clk_sys_in), .arst_n_in(arst_n_in), .avs_address(avs_address),
    .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
    .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
    .periph_trig_in(periph_trig_in), .conv_data_in(conv_data_in), .conv_ready_in(conv_ready_in),
    .converter_clock_tick_out(tick), .clk_source_out(src), .sync_enable_out(sync_en),
    .converter_active_flag_out(act), .group_active_flag_out(gact), .conv_start_out(cstart),
    .diag_enable_out(diag), .timer_source_sel_out(tsel), .scan_end_interrupt_out(irq));
  task end_sim; begin
    $display("compares %0d n_errors %0d", compares, n_errors);
    if (n_errors == 0 && compares > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  end endtask
  task hang; begin
    n_errors = n_errors + 1;
    end_sim;
  end endtask
  task bus(input rw, input [2:0] a, input [31:0] dat);
    integer i;
    reg w;
    begin
      @(posedge clk_sys_in);
      avs_address <= a;
      avs_writedata <= dat;
      avs_read <= !rw;
      avs_write <= rw;
      i = 0;
      // waitrequest sampled in the cycle before the accepting edge
      do begin
        @(negedge clk_sys_in);
        w = avs_waitrequest;
        q = avs_readdata;
        @(posedge clk_sys_in);
        i = i + 1;
      end while (w !== 1'b0 && i < 20);
      avs_read <= 1'b0;
      avs_write <= 1'b0;
      if (w !== 1'b0) hang;
      @(negedge clk_sys_in);
    end
  endtask
  task poll(input [2:0] a, input integer b, input v);
    integer i;
    begin
      i = 0;
      do begin bus(1'b0, a, 32'h0); i = i + 1; end while (q[b] !== v && i < 60);
      if (q[b] !== v) hang;
    end
  endtask
  task wirq;
    integer i;
    begin
      for (i = 0; irq !== 1'b1; i = i + 1) begin
        if (i == 300) hang;
        @(negedge clk_sys_in);
      end
    end
  endtask
  task feed(input [15:0] v, input [8:0] t); begin
    @(posedge clk_sys_in);
    conv_data_in <= v;
    conv_ready_in <= 1'b1;
    periph_trig_in <= t;
    @(posedge clk_sys_in);
    conv_ready_in <= 1'b0;
    periph_trig_in <= 9'h0;
  end endtask
  task t_reset; begin
    `CHK(sync_en, 2'h3)
    bus(1'b0, 3'h0, 32'h0);
    `CHK(q[10:0], 11'h001)
    bus(1'b1, 3'h7, 32'hFFFF_FFFF);
    bus(1'b0, 3'h7, 32'h0);
    `CHK(q, 32'h0)
    $display("reset test ended");
  end endtask
  task t_bringup; begin
    bus(1'b1, 3'h0, 32'h6);
    `CHK(sync_en, 2'h0)
    bus(1'b1, 3'h0, 32'h0);
    `CHK(sync_en, 2'h3)
    bus(1'b1, 3'h1, 32'h4);
    `CHK({tsel, src}, 3'h6)
    bus(1'b0, 3'h1, 32'h0);
    `CHK(q[7:0], 8'h04)
    bus(1'b0, 3'h2, 32'h0);
    `CHK(q[0], 1'b0)
    bus(1'b1, 3'h1, 32'h5);
    poll(3'h2, 0, 1'b1);
    `CHK(tick, 1'b1)
    $display("bring-up test ended");
  end endtask
  task t_nocal; begin
    bus(1'b1, 3'h3, 32'h0001_0000);
    repeat (20) @(negedge clk_sys_in);
    `CHK(gact, 9'h0)
    bus(1'b1, 3'h0, 32'h8);
    poll(3'h2, 1, 1'b1);
    $display("calibration test ended");
  end endtask
  task t_scan; begin
    bus(1'b1, 3'h0, 32'h80);
    feed(16'hA5C3, 9'h0);
    bus(1'b1, 3'h3, 32'h0004_0000);
    wirq;
    bus(1'b0, 3'h5, 32'h0);
    `CHK(q[15:0], 16'hA5C3)
    bus(1'b1, 3'h3, 32'h10);
    feed(16'h3C5A, 9'h020);
    repeat (3) @(negedge clk_sys_in);
    `CHK(gact, 9'h0)
    feed(16'h3C5A, 9'h010);
    wirq;
    bus(1'b0, 3'h5, 32'h0);
    `CHK(q[15:0], 16'h3C5A)
    $display("scan test ended");
  end endtask
  task t_bg; begin
    bus(1'b1, 3'h0, 32'h2E0);
    bus(1'b1, 3'h3, 32'h0001_0000);
    repeat (40) @(negedge clk_sys_in);
    feed(16'h1E2D, 9'h0);
    bus(1'b1, 3'h3, 32'h0001_0000);
    wirq;
    bus(1'b0, 3'h5, 32'h0);
    `CHK(q[15:0], 16'h1E2D)
    bus(1'b0, 3'h6, 32'h0);
    `CHK(q[15:0], 16'h1E2D)
    `CHK(gact[0], 1'b1)
    $display("background test ended");
  end endtask
  task t_clkchg; begin
    bus(1'b1, 3'h3, 32'h0);
    bus(1'b1, 3'h0, 32'h0);
    bus(1'b0, 3'h4, 32'h0);
    `CHK(q[8:0], 9'h000)
    bus(1'b1, 3'h1, 32'h4);
    poll(3'h2, 0, 1'b0);
    bus(1'b0, 3'h2, 32'h0);
    `CHK({q[1], gact}, 10'h0)
    for (m = 0; m < 7; m = m + 1) begin
      for (d = 0; d < 2; d = d + 1) begin
        bus(1'b1, 3'h0, 32'h400 | (d << 8) | (m << 4));
        `CHK(diag, m != 3 && (m < 5 || d == 1))
      end
    end
    bus(1'b1, 3'h1, 32'h13);
    `CHK({tsel, src}, 3'h1)
    poll(3'h2, 0, 1'b1);
    repeat (20) @(negedge clk_sys_in);
    bus(1'b1, 3'h0, 32'h8);
    poll(3'h2, 1, 1'b1);
    $display("clock change and diagnosis test ended");
  end endtask
  initial begin
    repeat (8) @(posedge clk_sys_in);
    arst_n_in <= 1'b1;
    repeat (3) @(posedge clk_sys_in);
    t_reset;
    t_bringup;
    t_nocal;
    t_scan;
    t_bg;
    t_clkchg;
    end_sim;
  end
endmodule // adss_top_test
